// ---- fsi_slave.sv ----
/*
  Pin-level slave of a 512 x 8 serial ferroelectric memory: framing,
  opcode decode, immediate byte writes, reads, status register and
  hardware/software write protection.
  Assumes the core clock is at least ten times the serial clock rate
  and that pins arrive asynchronously.
*/
`timescale 1ns/1ps

module fsi_slave
  import fsi_pkg::*;
#(
  parameter bit ERRATA_EN = 1'b1
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_o,
  output logic standby_o,
  output logic write_enable_latch_o
);

  // ****************************************************************
  // pin synchronisation and edge detection
  // ****************************************************************
  fsi_pin_type pins_raw;
  fsi_pin_type pins;
  logic sck_d;
  logic rise;
  logic fall;
  logic act;

  assign pins_raw = '{cs_n: cs_n_i, sck: sck_i, si: si_i, hold_n: hold_n_i, wp_n: wp_n_i};

  fsi_sync #(
    .WIDTH($bits(fsi_pin_type)),
    .INIT(5'h13)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(pins_raw),
    .sync_o(pins)
  );

  // previous clock level for edge finding, reset to the same idle level as the sync
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sck_d <= 1'b0;
    else
      sck_d <= pins.sck;
  end

  // static edges
  // edges are found from levels, so a stopped clock or any rate up to a tenth of the core clock is safe
  // either idle level
  // only level changes count, so mode 0 and mode 3 decode alike
  assign rise = pins.sck & ~sck_d;
  assign fall = ~pins.sck & sck_d;
  assign act = pins.hold_n & ~pins.cs_n;

  // ****************************************************************
  // protocol state
  // ****************************************************************
  fsi_state_type state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [7:0] tx, next_tx;
  logic [8:0] addr, next_addr;
  logic op_write, next_op_write;
  logic write_enable_latch, next_wel;
  logic [1:0] bp, next_bp;
  logic wpen, next_wpen;
  logic wel_pend, next_wel_pend;
  logic hi_write, next_hi_write;
  logic drive, next_drive;
  logic so, next_so;
  logic mem_we;
  logic [7:0] byte_in;
  logic [7:0] status;
  logic wr_ok;
  logic prot_hit;

  logic [7:0] mem [MEM_DEPTH];

  assign byte_in = {sh[6:0], pins.si};
  assign status = {wpen, 3'h0, bp, write_enable_latch, 1'b0};

  always_comb
  begin
    case (bp)
      BP_QUARTER: prot_hit = (addr >= QUARTER_BASE);
      BP_HALF: prot_hit = (addr >= HALF_BASE);
      BP_ALL: prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  end

  // otherwise the latch and block bits decide
  assign wr_ok = pins.wp_n & write_enable_latch;

  // next-state computation
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_tx = tx;
    next_addr = addr;
    next_op_write = op_write;
    next_wel = write_enable_latch;
    next_bp = bp;
    next_wpen = wpen;
    next_wel_pend = wel_pend;
    next_hi_write = hi_write;
    next_drive = drive;
    next_so = so;
    mem_we = 1'b0;
    if (!pins.hold_n)
    begin
      next_state = state;
    end
    else if (pins.cs_n)
    begin
      next_state = ST_IDLE;
      next_cnt = 3'h0;
      next_drive = 1'b0;
      if (wel_pend && !(ERRATA_EN && hi_write))
        next_wel = 1'b0;
      next_wel_pend = 1'b0;
      next_hi_write = 1'b0;
    end
    else if (state == ST_IDLE)
    begin
      // only edges after select are counted
      next_state = ST_CMD;
      next_cnt = 3'h0;
    end
    else if (rise && state != ST_IGNORE)
    begin
      next_sh = byte_in;
      next_cnt = 3'(cnt + 3'h1);
      if (cnt == 3'h7)
      begin
        case (state)
          ST_CMD:
          begin
            if (byte_in == OP_WREN)
            begin
              next_wel = 1'b1;
              next_state = ST_IGNORE;
            end
            else if (byte_in == OP_WRDI)
            begin
              next_wel = 1'b0;
              next_state = ST_IGNORE;
            end
            else if (byte_in == OP_RDSR)
            begin
              next_tx = status;
              next_state = ST_SRRD;
            end
            else if (byte_in == OP_WRSR)
            begin
              next_wel_pend = 1'b1;
              next_state = ST_SRWR;
            end
            else if ((byte_in & ~OP_A8_MASK) == OP_READ
                     || (byte_in & ~OP_A8_MASK) == OP_WRITE)
            begin
              next_addr = {byte_in[OP_A8_BIT], 8'h00};
              next_op_write = ((byte_in & ~OP_A8_MASK) == OP_WRITE);
              next_wel_pend = ((byte_in & ~OP_A8_MASK) == OP_WRITE);
              next_state = ST_ADDR;
            end
            else
            begin
              next_state = ST_IGNORE;
            end
          end
          ST_ADDR:
          begin
            next_addr = {addr[8], byte_in};
            next_tx = mem[{addr[8], byte_in}];
            next_state = op_write ? ST_WDATA : ST_RDATA;
          end
          ST_WDATA:
          begin
            mem_we = wr_ok && !prot_hit;
            if (addr >= ERRATA_LO)
              next_hi_write = 1'b1;
            next_addr = 9'(addr + 9'h001);
          end
          ST_SRWR:
          begin
            if (wr_ok)
            begin
              next_bp = byte_in[SR_BP_LO +: 2];
              next_wpen = byte_in[SR_WPEN_BIT];
            end
          end
          ST_RDATA:
          begin
            next_addr = 9'(addr + 9'h001);
            next_tx = mem[9'(addr + 9'h001)];
          end
          ST_SRRD:
            next_tx = status;
          default:
            next_state = state;
        endcase
      end
    end
    else if (fall && (state == ST_RDATA || state == ST_SRRD))
    begin
      next_so = tx[7];
      next_tx = {tx[6:0], 1'b0};
      next_drive = 1'b1;
    end
  end

  // protocol registers
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      addr <= 9'h000;
      op_write <= 1'b0;
      write_enable_latch <= 1'b0;
      bp <= BP_RESET;
      wpen <= WPEN_RESET;
      wel_pend <= 1'b0;
      hi_write <= 1'b0;
      drive <= 1'b0;
      so <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      tx <= next_tx;
      addr <= next_addr;
      op_write <= next_op_write;
      write_enable_latch <= next_wel;
      bp <= next_bp;
      wpen <= next_wpen;
      wel_pend <= next_wel_pend;
      hi_write <= next_hi_write;
      drive <= next_drive;
      so <= next_so;
    end
  end

  // nonvolatile array, no reset
  always_ff @(posedge core_clk_i)
  begin
    if (mem_we)
      mem[addr] <= byte_in;
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  // drive only while reading and not paused
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      standby_o <= 1'b1;
      write_enable_latch_o <= 1'b0;
    end
    else
    begin
      so_o <= next_so;
      so_oe_o <= next_drive & pins.hold_n & ~pins.cs_n;
      standby_o <= pins.cs_n;
      write_enable_latch_o <= next_wel;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_standby_tristate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pins.cs_n && pins.hold_n |=> !so_oe_o)
    else $error("output driven while deselected");

  chk_hold_tristate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !pins.hold_n |=> !so_oe_o)
    else $error("output driven during pause");

  chk_hold_freeze: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !pins.hold_n |=> $stable(state) && $stable(cnt) && $stable(addr))
    else $error("state moved during pause");

  chk_wp_blocks: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !pins.wp_n |-> !mem_we)
    else $error("array write while write-protect low");

  chk_bp_all: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mem_we |-> bp != BP_ALL && (bp != BP_HALF || !addr[8]))
    else $error("write into protected block");

  chk_rx_no_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
    so_oe_o |-> $past(state) == ST_RDATA || $past(state) == ST_SRRD)
    else $error("output driven outside a read");

  chk_out_on_fall: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $changed(so_o) |-> $past(fall))
    else $error("output changed away from a falling edge");

  chk_bad_opcode: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == ST_IGNORE && !pins.cs_n |=> state == ST_IGNORE && !drive)
    else $error("left ignore state without reselect");

  chk_write_commit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    act && rise && state == ST_WDATA && cnt == 3'h7 && wr_ok && bp == BP_NONE
    |-> mem_we ##1 state == ST_WDATA && cnt == 3'h0)
    else $error("completed byte not committed");

  chk_errata_latch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pins.hold_n && pins.cs_n && wel_pend && hi_write && ERRATA_EN && write_enable_latch |=> write_enable_latch)
    else $error("latch cleared after high write on affected part");

endmodule

// ---- fsi_pkg.sv ----
/*
  Package for the serial ferroelectric memory slave interface: opcodes,
  status register layout, protection bounds, pin bundle and state type.
  Assumes a single core clock that oversamples the serial pins.
*/
package fsi_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 512;

  // ****************************************************************
  // opcodes, the read/write pair carries address bit 8 in bit 3
  // ****************************************************************
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_A8_MASK = 8'h08;
  localparam int OP_A8_BIT = 3;

  // ****************************************************************
  // status register fields and reset values
  // ****************************************************************
  localparam int SR_WEL_BIT = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_WPEN_BIT = 7;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic WPEN_RESET = 1'b0;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [8:0] QUARTER_BASE = 9'h180;
  localparam logic [8:0] HALF_BASE = 9'h100;
  localparam logic [8:0] ERRATA_LO = 9'h100;

  // ****************************************************************
  // carrier and states
  // ****************************************************************
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } fsi_pin_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_SRRD, ST_SRWR, ST_IGNORE
  } fsi_state_type;

endpackage

// ---- fsi_sync.sv ----
/*
  Two flip-flop synchroniser for a bundle of asynchronous pins.
  Assumes the inputs are static long enough to be sampled twice.
*/
`timescale 1ns/1ps
module fsi_sync
  import fsi_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= INIT;
      sync_o <= INIT;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// ---- fsi_master_model.sv ----
/*
  Bus master model for the serial memory slave: drives select, clock,
  data, pause and write protect pins.
  Assumes the bench core clock; one serial clock period is 2*half+1 cycles.
*/
`timescale 1ns/1ps
module fsi_master_model
  import fsi_pkg::*;
(
  input wire logic core_clk_i,
  output fsi_pin_type pins_o
);
  logic cpol = 1'b0;
  logic busy = 1'b0;
  int half = 12;

  // ****************************************
  // pin driving
  // ****************************************
  initial pins_o = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  // released data line changes every cycle
  always @(posedge core_clk_i)
  begin
    if (!busy)
      pins_o.si <= ~pins_o.si;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // select edge, clock at idle level
  task automatic select();
    pins_o.sck <= cpol;
    busy <= 1'b1;
    wait_clk(4);
    pins_o.cs_n <= 1'b0;
    wait_clk(6);
  endtask

  // msb first, data moves with clock low
  task automatic xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--)
    begin
      pins_o.sck <= 1'b0;
      pins_o.si <= tx[i];
      wait_clk(half);
      pins_o.sck <= 1'b1;
      wait_clk(half + 1);
    end
  endtask

  task automatic deselect();
    pins_o.sck <= cpol;
    wait_clk(half);
    pins_o.cs_n <= 1'b1;
    busy <= 1'b0;
    wait_clk(8);
  endtask

  // pause moves only with clock low
  task automatic hold_low();
    pins_o.sck <= 1'b0;
    wait_clk(half);
    pins_o.hold_n <= 1'b0;
    wait_clk(6);
    repeat (2)
    begin
      pins_o.sck <= 1'b1;
      pins_o.cs_n <= 1'b1;
      wait_clk(half);
      pins_o.sck <= 1'b0;
      pins_o.cs_n <= 1'b0;
      wait_clk(half);
    end
  endtask

  task automatic hold_high();
    pins_o.hold_n <= 1'b1;
    wait_clk(6);
  endtask

  task automatic set_wp(input logic v);
    pins_o.wp_n <= v;
    wait_clk(4);
  endtask
endmodule

// ---- fsi_slave_tb.sv ----
/*
  Self-checking bench for the serial memory slave: writes, reads,
  in modes 0 and 3; protection, latch defect and bad opcode in mode 0, pause in mode 3.
  Assumes the master model and a 200 MHz core clock.
*/
`timescale 1ns/1ps
module fsi_slave_tb
  import fsi_pkg::*;
;
  logic core_clk;
  logic rst;
  logic no_out = 1'b1;
  logic [31:0] seed = 32'h41D2935D;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] exp_q [$];
  logic [7:0] sh = 8'h00;
  logic [8:0] bnd [4] = '{9'h0FF, 9'h100, 9'h17F, 9'h180};
  logic [9:0] base [4] = '{10'h200, 10'h180, 10'h100, 10'h000};
  int nb = 0;
  int num_errors = 0;
  int checks_done = 0;
  fsi_pin_type pins;
  logic so, so_oe, standby, write_enable_latch;

  always #2.5 core_clk = ~core_clk;

  fsi_master_model i_m (.core_clk_i(core_clk), .pins_o(pins));

  fsi_slave i_dut (
    .core_clk_i(core_clk), .rst_i(rst), .cs_n_i(pins.cs_n), .sck_i(pins.sck),
    .si_i(pins.si), .hold_n_i(pins.hold_n), .wp_n_i(pins.wp_n), .so_o(so),
    .so_oe_o(so_oe), .standby_o(standby), .write_enable_latch_o(write_enable_latch)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function automatic logic [7:0] op_a(input logic [7:0] op, input logic [8:0] a);
    return op | ({7'h00, a[8]} << OP_A8_BIT);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
      num_errors++;
    end
  endtask

  task automatic frame(input logic [7:0] op, input logic [7:0] arg, input logic rdf);
    no_out = !rdf;
    i_m.select();
    i_m.xfer(op);
    i_m.xfer(arg);
    i_m.deselect();
    no_out = 1'b1;
  endtask

  task automatic wr(input logic [8:0] a, input int n, input logic ok);
    logic [7:0] d;
    i_m.select();
    i_m.xfer(op_a(OP_WRITE, a));
    i_m.xfer(a[7:0]);
    for (int i = 0; i < n; i++)
    begin
      d = rnd();
      i_m.xfer(d);
      if (ok)
        mem[9'(a + i)] = d;
    end
    i_m.deselect();
  endtask

  task automatic rd(input logic [8:0] a, input int n, input logic hp);
    for (int i = 0; i < n; i++)
      exp_q.push_back(mem[9'(a + i)]);
    no_out = 1'b0;
    i_m.select();
    i_m.xfer(op_a(OP_READ, a));
    i_m.xfer(a[7:0]);
    for (int i = 0; i < n; i++)
    begin
      if (hp && i == 1)
      begin
        i_m.hold_low();
        chk({6'h00, standby, so_oe}, 8'h00);
        i_m.hold_high();
      end
      i_m.xfer(8'h00);
    end
    i_m.deselect();
    no_out = 1'b1;
  endtask

  task automatic close_out();
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // collect read bits on rising clock, oldest note compared
  always @(posedge pins.sck)
  begin
    if (so_oe === 1'b1)
    begin
      sh = {sh[6:0], so};
      nb++;
      if (nb == 8)
      begin
        nb = 0;
        chk(sh, (exp_q.size() > 0) ? exp_q.pop_front() : ~sh);
      end
    end
  end

  always @(posedge pins.cs_n) nb = 0;

  always @(posedge core_clk)
  begin
    if (!rst && no_out && so_oe !== 1'b0)
      chk({7'h00, so_oe}, 8'h00);
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({5'h00, standby, so_oe, write_enable_latch}, 8'h04);
    frame(OP_WREN, 8'h00, 1'b0);
    chk({7'h00, write_enable_latch}, 8'h01);
    exp_q.push_back(8'h02);
    frame(OP_RDSR, 8'h00, 1'b1);
    wr(9'h0F0, 4, 1'b1);
    chk({7'h00, write_enable_latch}, 8'h00);
    rd(9'h0F0, 4, 1'b0);
    frame(OP_WREN, 8'h00, 1'b0);
    wr(9'h1FE, 3, 1'b1);
    chk({7'h00, write_enable_latch}, 8'h01);
    rd(9'h1FE, 3, 1'b0);
    frame(OP_WRDI, 8'h00, 1'b0);
    chk({7'h00, write_enable_latch}, 8'h00);
    wr(9'h0F1, 1, 1'b0);
    i_m.set_wp(1'b0);
    frame(OP_WREN, 8'h00, 1'b0);
    wr(9'h0F2, 1, 1'b0);
    frame(OP_WREN, 8'h00, 1'b0);
    frame(OP_WRSR, 8'h0C, 1'b0);
    frame(OP_WRDI, 8'h00, 1'b0);
    i_m.set_wp(1'b1);
    exp_q.push_back(8'h00);
    frame(OP_RDSR, 8'h00, 1'b1);
    rd(9'h0F1, 2, 1'b0);
    // each protect code against block edges
    for (int b = 0; b < 4; b++)
    begin
      frame(OP_WREN, 8'h00, 1'b0);
      frame(OP_WRSR, {4'h0, 2'(b), 2'h0}, 1'b0);
      exp_q.push_back({4'h0, 2'(b), 2'h0});
      frame(OP_RDSR, 8'h00, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
        frame(OP_WREN, 8'h00, 1'b0);
        wr(bnd[k], 1, {1'b0, bnd[k]} < base[b]);
        rd(bnd[k], 1, 1'b0);
      end
    end
    frame(OP_WREN, 8'h00, 1'b0);
    frame(OP_WRSR, 8'h00, 1'b0);
    // clock idles high and runs slower
    i_m.cpol = 1'b1;
    i_m.half = 40;
    frame(OP_WREN, 8'h00, 1'b0);
    wr(9'h033, 3, 1'b1);
    rd(9'h033, 3, 1'b1);
    i_m.cpol = 1'b0;
    i_m.half = 12;
    i_m.select();
    i_m.xfer(8'hFF);
    i_m.xfer(OP_READ);
    i_m.xfer(8'h33);
    i_m.xfer(8'h00);
    chk({7'h00, so_oe}, 8'h00);
    i_m.deselect();
    rd(9'h1FF, 2, 1'b0);
    chk(8'(exp_q.size()), 8'h00);
    close_out();
  end

  // watchdog against a hang
  initial
  begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule
